// ==== logic/acc_ops_pkg.sv ====
// constants and types shared by the accumulator add/and datapath
package acc_ops_pkg;

  // ************************************************************
  // widths and instruction encodings
  // ************************************************************
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned INSN_W  = 12;
  localparam int unsigned FADDR_W = 5;

  localparam logic [5:0] OP_ADD_ACC_TO_FILE    = 6'h07;  // 0001 11
  localparam logic [5:0] OP_AND_ACC_TO_FILE    = 6'h05;  // 0001 01
  localparam logic [3:0] OP_AND_LITERAL        = 4'hE;   // 1110
  localparam logic [8:0] OP_PIN_DIRECTION_LOAD = 9'h000; // 0000 0000 0
  localparam logic [2:0] PIN_DIR_PORT_ADDR     = 3'h6;
  localparam logic [FADDR_W-1:0] TIMER_COUNT_ADDR = 5'h01;

  // instruction field positions
  localparam int unsigned DEST_BIT      = 5;
  localparam int unsigned OPC_SHORT_LSB = 8;
  localparam int unsigned OPC_FILE_LSB  = 6;
  localparam int unsigned OPC_CTRL_LSB  = 3;

  // ************************************************************
  // status flag positions and reset values
  // ************************************************************
  localparam int unsigned FLAG_CARRY = 0;
  localparam int unsigned FLAG_HALF  = 1;
  localparam int unsigned FLAG_ZERO  = 2;
  localparam logic [2:0]        FLAGS_RESET = 3'h0;
  localparam logic [DATA_W-1:0] ACC_RESET   = 8'h00;
  localparam logic [DATA_W-1:0] DIR_RESET   = 8'hFF;

  // ************************************************************
  // software register map (word index on the plain port)
  // ************************************************************
  localparam int unsigned  REG_ADDR_W = 2;
  localparam logic [1:0]   REG_ACC    = 2'h0;
  localparam logic [1:0]   REG_FLAGS  = 2'h1;
  localparam logic [1:0]   REG_DIR    = 2'h2;
  localparam logic [1:0]   REG_CTRL   = 2'h3;
  localparam int unsigned  CTRL_PRESCALER_TO_TIMER = 0;
  localparam logic         CTRL_RESET = 1'b0;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic               en;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0]  data;
  } file_wr_s;

endpackage

// ==== logic/acc_add_and_ops.sv ====
// accumulator add/and datapath with direction-latch load and prescaler clear
// ************************************************************
// Function
// - direction-load to address 6 copies accumulator
// - result written to timer clears assigned prescaler
// - add accumulator to file, flags, one cycle
// - dest bit 0 accumulator, 1 file register
// - and accumulator with file, zero only
// - and literal into accumulator, zero only
// ************************************************************
module acc_add_and_ops
(
  input  wire logic                                   clk_i,
  input  wire logic                                   reset_n_i,
  input  wire logic                                   insn_valid_i,
  input  wire logic [acc_ops_pkg::INSN_W-1:0]         insn_i,
  input  wire logic [acc_ops_pkg::DATA_W-1:0]         file_rdata_i,
  input  wire logic [acc_ops_pkg::REG_ADDR_W-1:0]     reg_addr_i,
  input  wire logic [acc_ops_pkg::DATA_W-1:0]         reg_wdata_i,
  input  wire logic                                   reg_write_i,
  input  wire logic                                   reg_read_i,
  output logic [acc_ops_pkg::DATA_W-1:0]              reg_rdata_o,
  output acc_ops_pkg::file_wr_s                       file_wr_o,
  output logic [acc_ops_pkg::DATA_W-1:0]              acc_o,
  output logic [2:0]                                  flags_o,
  output logic [acc_ops_pkg::DATA_W-1:0]              pin_dir_o,
  output logic                                        prescaler_clr_o
);

  // ************************************************************
  // decode
  // ************************************************************
  logic                               is_add;
  logic                               is_andf;
  logic                               is_andl;
  logic                               is_dir;
  logic                               dest_file;
  logic [acc_ops_pkg::FADDR_W-1:0]    faddr;
  logic [acc_ops_pkg::DATA_W:0]       sum;
  logic [4:0]                         low_sum;
  logic [acc_ops_pkg::DATA_W-1:0]     result;
  logic                               writes_result;
  logic [3:0]                         opc_short;
  logic [5:0]                         opc_file;
  logic [8:0]                         opc_ctrl;
  logic [2:0]                         ctrl_port;
  logic [acc_ops_pkg::DATA_W-1:0]     literal;

  // ************************************************************
  // instruction fields
  // ************************************************************
  assign opc_short = insn_i[acc_ops_pkg::INSN_W-1:acc_ops_pkg::OPC_SHORT_LSB];
  assign opc_file  = insn_i[acc_ops_pkg::INSN_W-1:acc_ops_pkg::OPC_FILE_LSB];
  assign opc_ctrl  = insn_i[acc_ops_pkg::INSN_W-1:acc_ops_pkg::OPC_CTRL_LSB];
  assign ctrl_port = insn_i[acc_ops_pkg::OPC_CTRL_LSB-1:0];
  assign literal   = insn_i[acc_ops_pkg::DATA_W-1:0];

  assign is_add    = insn_valid_i && (opc_file == acc_ops_pkg::OP_ADD_ACC_TO_FILE);
  assign is_andf   = insn_valid_i && (opc_file == acc_ops_pkg::OP_AND_ACC_TO_FILE);
  assign is_andl   = insn_valid_i && (opc_short == acc_ops_pkg::OP_AND_LITERAL);
  assign is_dir    = insn_valid_i && (opc_ctrl == acc_ops_pkg::OP_PIN_DIRECTION_LOAD)
                     && (ctrl_port == acc_ops_pkg::PIN_DIR_PORT_ADDR);
  assign dest_file = insn_i[acc_ops_pkg::DEST_BIT];
  assign faddr     = insn_i[acc_ops_pkg::FADDR_W-1:0];

  // ************************************************************
  // arithmetic
  // ************************************************************
  assign sum     = {1'b0, acc_o} + {1'b0, file_rdata_i};
  assign low_sum = {1'b0, acc_o[3:0]} + {1'b0, file_rdata_i[3:0]};

  always_comb
  begin
    result = acc_o;
    if (is_add)
    begin
      result = sum[acc_ops_pkg::DATA_W-1:0];
    end
    else if (is_andf)
    begin
      result = acc_o & file_rdata_i;
    end
    else if (is_andl)
    begin
      result = acc_o & literal;
    end
  end

  assign writes_result = is_add || is_andf || is_andl;

  // ************************************************************
  // accumulator
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      acc_o <= acc_ops_pkg::ACC_RESET;
    end
    else if (is_andl || ((is_add || is_andf) && !dest_file))
    begin
      acc_o <= result;
    end
    // an instruction update wins over a software write in the same cycle
    else if (reg_write_i && reg_addr_i == acc_ops_pkg::REG_ACC)
    begin
      acc_o <= reg_wdata_i;
    end
  end

  // ************************************************************
  // file register write-back
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      file_wr_o <= '0;
    end
    else
    begin
      // addr and data track every cycle; only en qualifies them
      file_wr_o.en   <= (is_add || is_andf) && dest_file;
      file_wr_o.addr <= faddr;
      file_wr_o.data <= result;
    end
  end

  // ************************************************************
  // status flags
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      flags_o <= acc_ops_pkg::FLAGS_RESET;
    end
    else if (writes_result)
    begin
      // and-type ops leave carry and half carry untouched
      flags_o[acc_ops_pkg::FLAG_ZERO] <= (result == 8'h00);
      if (is_add)
      begin
        flags_o[acc_ops_pkg::FLAG_CARRY] <= sum[acc_ops_pkg::DATA_W];
        flags_o[acc_ops_pkg::FLAG_HALF]  <= low_sum[4];
      end
    end
    else if (reg_write_i && reg_addr_i == acc_ops_pkg::REG_FLAGS)
    begin
      flags_o <= reg_wdata_i[2:0];
    end
  end

  // ************************************************************
  // pin direction latches, 1 means high impedance
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      pin_dir_o <= acc_ops_pkg::DIR_RESET;
    end
    else if (is_dir)
    begin
      pin_dir_o <= acc_o;
    end
  end

  // ************************************************************
  // prescaler clear and its assignment control
  // ************************************************************
  logic ctrl_q;

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_q <= acc_ops_pkg::CTRL_RESET;
    end
    else if (reg_write_i && reg_addr_i == acc_ops_pkg::REG_CTRL)
    begin
      ctrl_q <= reg_wdata_i[acc_ops_pkg::CTRL_PRESCALER_TO_TIMER];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      prescaler_clr_o <= 1'b0;
    end
    else
    begin
      prescaler_clr_o <= (is_add || is_andf) && dest_file && ctrl_q
                         && (faddr == acc_ops_pkg::TIMER_COUNT_ADDR);
    end
  end

  // ************************************************************
  // register read port, data valid only the cycle after the strobe
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      reg_rdata_o <= 8'h00;
    end
    else if (reg_read_i)
    begin
      unique case (reg_addr_i)
        acc_ops_pkg::REG_ACC:   reg_rdata_o <= acc_o;
        acc_ops_pkg::REG_FLAGS: reg_rdata_o <= {5'h00, flags_o};
        acc_ops_pkg::REG_DIR:   reg_rdata_o <= pin_dir_o;
        acc_ops_pkg::REG_CTRL:  reg_rdata_o <= {7'h00, ctrl_q};
      endcase
    end
    else
    begin
      reg_rdata_o <= 8'h00;
    end
  end

endmodule

// ==== verification/acc_ops_checker.sv ====
// port assertions for the accumulator add/and datapath
// ************************************************************
// checker
// ************************************************************
module acc_ops_checker
(
  input wire logic                  clk_i,
  input wire logic                  reset_n_i,
  input wire logic                  insn_valid_i,
  input wire logic [11:0]           insn_i,
  input wire logic [7:0]            file_rdata_i,
  input wire acc_ops_pkg::file_wr_s file_wr_o,
  input wire logic [7:0]            acc_o,
  input wire logic [2:0]            flags_o,
  input wire logic [7:0]            pin_dir_o,
  input wire logic                  prescaler_clr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  dir_load_a: assert property (insn_valid_i && insn_i == 12'h006 |=> pin_dir_o == $past(acc_o))
    else $error("direction latches not loaded");
  presc_clr_a: assert property (prescaler_clr_o |-> $past(insn_valid_i) &&
    ($past(insn_i) inside {12'h161, 12'h1E1}))
    else $error("prescaler clear without timer write");
  add_file_a: assert property (insn_valid_i && insn_i[11:5] == 7'h0F |=> file_wr_o.en &&
    file_wr_o.addr == $past(insn_i[4:0]) && file_wr_o.data == $past(acc_o) + $past(file_rdata_i))
    else $error("add to file wrong");
  add_acc_a: assert property (insn_valid_i && insn_i[11:5] == 7'h0E |=> !file_wr_o.en &&
    acc_o == $past(acc_o) + $past(file_rdata_i) && flags_o[2] == (acc_o == 8'h00))
    else $error("add to accumulator wrong");
  add_flags_a: assert property (insn_valid_i && insn_i[11:6] == 6'h07 |=>
    flags_o[0] == ($past(acc_o) + $past(file_rdata_i) > 9'h0FF) &&
    flags_o[1] == ($past(acc_o[3:0]) + $past(file_rdata_i[3:0]) > 5'h0F))
    else $error("add carry flags wrong");
  and_file_a: assert property (insn_valid_i && insn_i[11:6] == 6'h05 |=>
    flags_o[1:0] == $past(flags_o[1:0]) && flags_o[2] == (($past(acc_o) & $past(file_rdata_i)) == 8'h00) &&
    (file_wr_o.en ? file_wr_o.data : acc_o) == ($past(acc_o) & $past(file_rdata_i)))
    else $error("and with file wrong");
  and_lit_a: assert property (insn_valid_i && insn_i[11:8] == 4'hE |=> !file_wr_o.en &&
    acc_o == ($past(acc_o) & $past(insn_i[7:0])) && flags_o[2] == (acc_o == 8'h00))
    else $error("and literal wrong");
endmodule

bind acc_add_and_ops acc_ops_checker u_acc_ops_checker (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .insn_valid_i(insn_valid_i), .insn_i(insn_i), .file_rdata_i(file_rdata_i), .file_wr_o(file_wr_o),
  .acc_o(acc_o), .flags_o(flags_o), .pin_dir_o(pin_dir_o), .prescaler_clr_o(prescaler_clr_o));

// ==== verification/tb_top.sv ====
// self-checking bench for the accumulator add/and datapath
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; $display("BAD %0t %h %h", $time, a, b); end end
  logic                  clk_i = 0, reset_n_i = 0, insn_valid_i = 0, reg_write_i = 0, reg_read_i = 0;
  logic [11:0]           insn_i = 0;
  logic [7:0]            file_rdata_i = 0, reg_wdata_i = 0, reg_rdata_o, acc_o, pin_dir_o, r, m_acc = 0, m_dir = 8'hFF;
  logic [1:0]            reg_addr_i = 0;
  logic [2:0]            flags_o, m_fl = 0;
  logic [8:0]            s;
  logic                  prescaler_clr_o, m_ctl = 0, clr, wen, fop;
  logic [31:0]           sd = 32'h8EA9D228;
  logic [11:0]           base[6] = '{12'h1C0, 12'h140, 12'hE00, 12'h006, 12'h005, 12'hA00};
  logic [11:0]           msk[6] = '{12'h03F, 12'h03F, 12'h0FF, 12'h000, 12'h000, 12'h0FF};
  acc_ops_pkg::file_wr_s file_wr_o;
  int                    n_fail = 0, checks = 0;

  initial forever #2.5 clk_i = ~clk_i;

  acc_add_and_ops u_acc_add_and_ops (.clk_i(clk_i), .reset_n_i(reset_n_i), .insn_valid_i(insn_valid_i),
    .insn_i(insn_i), .file_rdata_i(file_rdata_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .file_wr_o(file_wr_o),
    .acc_o(acc_o), .flags_o(flags_o), .pin_dir_o(pin_dir_o), .prescaler_clr_o(prescaler_clr_o));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clk_i);
    reg_write_i <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clk_i);
    reg_read_i <= 1'b0;
    #1 `CHK(reg_rdata_o, e)
  endtask

  // ************************************************************
  // one instruction against the reference model
  // ************************************************************
  task automatic ex(input logic [11:0] i, input logic [7:0] f);
    @(posedge clk_i);
    insn_valid_i <= 1'b1;
    insn_i       <= i;
    file_rdata_i <= f;
    @(posedge clk_i);
    insn_valid_i <= 1'b0;
    fop = i[11:8] == 4'h1 && i[6];
    s = m_acc + f;
    r = fop && i[7] ? s[7:0] : (i[11:8] == 4'hE ? m_acc & i[7:0] : m_acc & f);
    wen = fop && i[5];
    clr = wen && i[4:0] == 5'h01 && m_ctl;
    if (i == 12'h006)
      m_dir = m_acc;
    if (fop && i[7])
      m_fl[1:0] = {(m_acc[3:0] + f[3:0]) > 15, s[8]};
    if (fop || i[11:8] == 4'hE)
    begin
      m_fl[2] = r == 8'h00;
      if (!wen)
        m_acc = r;
    end
    #1;
    `CHK(acc_o, m_acc)
    `CHK(flags_o, m_fl)
    `CHK(file_wr_o.en, wen)
    if (wen) `CHK({file_wr_o.addr, file_wr_o.data}, {i[4:0], r})
    `CHK(pin_dir_o, m_dir)
    `CHK(prescaler_clr_o, clr)
  endtask

  task automatic end_sim;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    n_fail++;
    end_sim();
  end

  initial
  begin
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(acc_ops_pkg::REG_DIR, 8'hFF);
    wr(acc_ops_pkg::REG_CTRL, 8'h01);
    m_ctl = 1;
    wr(acc_ops_pkg::REG_ACC, 8'h17);
    m_acc = 8'h17;
    ex(12'h1E1, 8'hC2);
    wr(acc_ops_pkg::REG_ACC, 8'hA3);
    m_acc = 8'hA3;
    ex(12'hE5F, 8'h00);
    // direction latches must ignore software writes
    wr(acc_ops_pkg::REG_DIR, 8'h5A);
    rd(acc_ops_pkg::REG_DIR, m_dir);
    $display("directed tests done");
    repeat (400)
    begin
      sd = xs(sd);
      ex(base[sd[31:16] % 6] | (sd[11:0] & msk[sd[31:16] % 6]), sd[23:16]);
      if (sd[28:26] == 3'h0)
      begin
        wr(acc_ops_pkg::REG_CTRL, {7'h00, sd[12]});
        m_ctl = sd[12];
        wr(acc_ops_pkg::REG_FLAGS, {5'h00, sd[15:13]});
        m_fl = sd[15:13];
        rd(acc_ops_pkg::REG_FLAGS, {5'h00, m_fl});
        rd(acc_ops_pkg::REG_ACC, m_acc);
      end
    end
    $display("random tests done");
    end_sim();
  end
endmodule
